// ### common/spxu_consts.vh
`ifndef SPXU_CONSTS_VH
`define SPXU_CONSTS_VH

// opcode selects
`define SPXU_OP_W         4
`define SPXU_OP_MASK      4'h0
`define SPXU_OP_WPERM64   4'h1
`define SPXU_OP_LOPERM    4'h2
`define SPXU_OP_HIPERM    4'h3
`define SPXU_OP_DPERM     4'h4
`define SPXU_OP_BSHUF     4'h5
`define SPXU_OP_BLENDB_I  4'h6
`define SPXU_OP_BLENDW_I  4'h7
`define SPXU_OP_BLENDB_V  4'h8
`define SPXU_OP_INSFP     4'h9
`define SPXU_OP_INSB      4'hA
`define SPXU_OP_INSW      4'hB
`define SPXU_OP_INSD      4'hC
`define SPXU_OP_EXTB      4'hD
`define SPXU_OP_EXTW      4'hE
`define SPXU_OP_EXTD      4'hF

// element size codes for insert and extract
`define SPXU_SZ_BYTE      2'h0
`define SPXU_SZ_WORD      2'h1
`define SPXU_SZ_DWORD     2'h2

`define SPXU_VEC_W        128
`define SPXU_HALF_W       64
`define SPXU_INT_W        32
`define SPXU_MASK64_W     8
`define SPXU_MASK128_W    16
`define SPXU_LAT          2
`define SPXU_BSHUF_ZERO   7
`define SPXU_CNT_W        2

`endif

// ### hdl/spxu_permute_unit.v
`timescale 1ns/1ps
`include "spxu_consts.vh"

// Operation
// - sign mask takes top bit of each byte, in byte order.
// - 64-bit source gives 8 mask bits, upper 24 bits zero.
// - 128-bit source gives 16 mask bits, upper 16 bits zero.
// - 64-bit word permute picks any source word per result word.
// - 64-bit permute source is register or memory; result to register.
// - control bit pairs 1-0,3-2,5-4,7-6 select elements 0..3.
// - low/high half permutes shuffle four words inside chosen half.
// - unselected half passes through unchanged.
// - dword permute routes any of four dwords to any result dword.
// - byte shuffle picks bytes only within one 16-byte vector.
// - byte/word blends replace masked elements with same-position source.
// - blend mask from control byte or implicit mask vector, per variant.
// - insert loads one memory element into a chosen register position.
// - extract stores one register element straight to memory.
// - insert writes only the addressed element, others kept.
module spxu_permute_unit (
  input  wire                   clk,
  input  wire                   sys_rst,
  input  wire                   opValid,
  input  wire [`SPXU_OP_W-1:0]  opSel,
  input  wire [`SPXU_VEC_W-1:0] dstVec,
  input  wire [`SPXU_VEC_W-1:0] srcVec,
  input  wire [`SPXU_HALF_W-1:0] memOperand,
  input  wire                   srcFromMem,
  input  wire [`SPXU_VEC_W-1:0] implicitMaskVector,
  input  wire [7:0]             shuffleControlByte,
  output reg                    resValid,
  output reg  [`SPXU_VEC_W-1:0] resVec,
  output reg  [`SPXU_INT_W-1:0] resInt,
  output reg                    resIntWrite,
  output reg                    storeValid,
  output reg  [`SPXU_INT_W-1:0] storeData,
  output reg  [1:0]             storeSize
);
  // stage 1 captures operands together with valid
  reg                    s1Valid;
  reg [`SPXU_OP_W-1:0]   s1Op;
  reg [`SPXU_VEC_W-1:0]  s1Dst;
  reg [`SPXU_VEC_W-1:0]  s1Src;
  reg [`SPXU_HALF_W-1:0] s1Mem;
  reg                    s1FromMem;
  reg [`SPXU_VEC_W-1:0]  s1MaskVec;
  reg [7:0]              s1Ctrl;

  always @(posedge clk) begin
    if (sys_rst) begin
      s1Valid   <= 1'b0;
      s1Op      <= `SPXU_OP_MASK;
      s1Dst     <= {`SPXU_VEC_W{1'b0}};
      s1Src     <= {`SPXU_VEC_W{1'b0}};
      s1Mem     <= {`SPXU_HALF_W{1'b0}};
      s1FromMem <= 1'b0;
      s1MaskVec <= {`SPXU_VEC_W{1'b0}};
      s1Ctrl    <= 8'h00;
    end else begin
      s1Valid <= opValid;
      if (opValid) begin
        s1Op      <= opSel;
        s1Dst     <= dstVec;
        s1Src     <= srcVec;
        s1Mem     <= memOperand;
        s1FromMem <= srcFromMem;
        s1MaskVec <= implicitMaskVector;
        s1Ctrl    <= shuffleControlByte;
      end
    end
  end

  // element size code by opcode, shared by insert and extract
  function [1:0] elemSize;
    input [`SPXU_OP_W-1:0] op;
    begin
      case (op)
        `SPXU_OP_INSB, `SPXU_OP_EXTB: elemSize = `SPXU_SZ_BYTE;
        `SPXU_OP_INSW, `SPXU_OP_EXTW: elemSize = `SPXU_SZ_WORD;
        default:                      elemSize = `SPXU_SZ_DWORD;
      endcase
    end
  endfunction

  wire [`SPXU_HALF_W-1:0] wpSrc = s1FromMem ? s1Mem : s1Src[`SPXU_HALF_W-1:0];
  wire [`SPXU_HALF_W-1:0] wpOut;
  wire [`SPXU_HALF_W-1:0] loOut;
  wire [`SPXU_HALF_W-1:0] hiOut;
  wire [`SPXU_VEC_W-1:0]  dOut;
  wire [`SPXU_INT_W-1:0]  maskInt;

  spxu_sign_mask uMask (
    .srcVec  (s1Src),
    .wide    (s1FromMem == 1'b0),
    .maskOut (maskInt)
  );

  spxu_word_perm #(.LANE(16)) uWp64 (
    .srcIn    (wpSrc),
    .ctrlByte (s1Ctrl),
    .dstOut   (wpOut)
  );

  spxu_word_perm #(.LANE(16)) uLo (
    .srcIn    (s1Src[`SPXU_HALF_W-1:0]),
    .ctrlByte (s1Ctrl),
    .dstOut   (loOut)
  );

  spxu_word_perm #(.LANE(16)) uHi (
    .srcIn    (s1Src[`SPXU_VEC_W-1:`SPXU_HALF_W]),
    .ctrlByte (s1Ctrl),
    .dstOut   (hiOut)
  );

  spxu_word_perm #(.LANE(32)) uDw (
    .srcIn    (s1Src),
    .ctrlByte (s1Ctrl),
    .dstOut   (dOut)
  );

  // byte shuffle: control bytes are in the source operand; index only 4 bits,
  // bit 7 zeroes the byte; a wider index cannot escape the 16-byte vector
  wire [`SPXU_VEC_W-1:0] bOut;
  // blends
  wire [`SPXU_VEC_W-1:0] blendBImm;
  wire [`SPXU_VEC_W-1:0] blendWImm;
  wire [`SPXU_VEC_W-1:0] blendBVec;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gByte
      wire [3:0] idx = s1Src[8*g+3:8*g];
      assign bOut[8*g +: 8] = s1Src[8*g+`SPXU_BSHUF_ZERO] ? 8'h00
                              : s1Dst[8*idx +: 8];
      // immediate byte blend: control bit repeats per half
      assign blendBImm[8*g +: 8] = s1Ctrl[g%8] ? s1Src[8*g +: 8]
                                               : s1Dst[8*g +: 8];
      assign blendBVec[8*g +: 8] = s1MaskVec[8*g+7] ? s1Src[8*g +: 8]
                                                    : s1Dst[8*g +: 8];
    end
    for (g = 0; g < 8; g = g + 1) begin : gWord
      assign blendWImm[16*g +: 16] = s1Ctrl[g] ? s1Src[16*g +: 16]
                                               : s1Dst[16*g +: 16];
    end
  endgenerate

  // insert: index from low control bits, only the addressed element replaced
  reg [`SPXU_VEC_W-1:0] insOut;
  reg [`SPXU_INT_W-1:0] extOut;
  always @* begin
    insOut = s1Dst;
    extOut = {`SPXU_INT_W{1'b0}};
    case (elemSize(s1Op))
      `SPXU_SZ_BYTE: begin
        insOut[8*s1Ctrl[3:0] +: 8] = s1Mem[7:0];
        extOut = {24'h00_0000, s1Src[8*s1Ctrl[3:0] +: 8]};
      end
      `SPXU_SZ_WORD: begin
        insOut[16*s1Ctrl[2:0] +: 16] = s1Mem[15:0];
        extOut = {16'h0000, s1Src[16*s1Ctrl[2:0] +: 16]};
      end
      default: begin
        // floating-point insert shares the dword path
        insOut[32*s1Ctrl[1:0] +: 32] = s1Mem[31:0];
        extOut = s1Src[32*s1Ctrl[1:0] +: 32];
      end
    endcase
  end

  reg [`SPXU_VEC_W-1:0] next_resVec;
  reg [`SPXU_INT_W-1:0] next_resInt;
  reg                   next_intWr;
  reg                   next_store;
  always @* begin
    next_resVec = {`SPXU_VEC_W{1'b0}};
    next_resInt = {`SPXU_INT_W{1'b0}};
    next_intWr  = 1'b0;
    next_store  = 1'b0;
    case (s1Op)
      `SPXU_OP_MASK: begin
        next_resInt = maskInt;
        next_intWr  = 1'b1;
      end
      `SPXU_OP_WPERM64: next_resVec = {64'h0000_0000_0000_0000, wpOut};
      `SPXU_OP_LOPERM:  next_resVec = {s1Src[`SPXU_VEC_W-1:`SPXU_HALF_W], loOut};
      `SPXU_OP_HIPERM:  next_resVec = {hiOut, s1Src[`SPXU_HALF_W-1:0]};
      `SPXU_OP_DPERM:   next_resVec = dOut;
      `SPXU_OP_BSHUF:   next_resVec = bOut;
      `SPXU_OP_BLENDB_I: next_resVec = blendBImm;
      `SPXU_OP_BLENDW_I: next_resVec = blendWImm;
      `SPXU_OP_BLENDB_V: next_resVec = blendBVec;
      `SPXU_OP_INSFP, `SPXU_OP_INSB, `SPXU_OP_INSW, `SPXU_OP_INSD: next_resVec = insOut;
      `SPXU_OP_EXTB, `SPXU_OP_EXTW, `SPXU_OP_EXTD: begin
        next_resVec = s1Src;
        next_store  = 1'b1;
      end
      default: next_resVec = s1Src;
    endcase
  end

  // fixed two-cycle latency regardless of operand values
  always @(posedge clk) begin
    if (sys_rst) begin
      resValid    <= 1'b0;
      resVec      <= {`SPXU_VEC_W{1'b0}};
      resInt      <= {`SPXU_INT_W{1'b0}};
      resIntWrite <= 1'b0;
      storeValid  <= 1'b0;
      storeData   <= {`SPXU_INT_W{1'b0}};
      storeSize   <= `SPXU_SZ_BYTE;
    end else begin
      resValid    <= s1Valid;
      resIntWrite <= s1Valid & next_intWr;
      storeValid  <= s1Valid & next_store;
      if (s1Valid) begin
        resVec    <= next_resVec;
        resInt    <= next_resInt;
        storeData <= extOut;
        storeSize <= elemSize(s1Op);
      end
    end
  end
endmodule // spxu_permute_unit

// ### hdl/spxu_sign_mask.v
`timescale 1ns/1ps
`include "spxu_consts.vh"

module spxu_sign_mask (
  input  wire [`SPXU_VEC_W-1:0] srcVec,
  input  wire                   wide,
  output wire [`SPXU_INT_W-1:0] maskOut
);
  wire [`SPXU_MASK128_W-1:0] topBits;

  genvar i;
  generate
    for (i = 0; i < `SPXU_MASK128_W; i = i + 1) begin : gTop
      assign topBits[i] = srcVec[8*i+7];
    end
  endgenerate

  assign maskOut = wide ? {16'h0000, topBits}
                        : {24'h00_0000, topBits[`SPXU_MASK64_W-1:0]};
endmodule // spxu_sign_mask

// ### hdl/spxu_word_perm.v
`timescale 1ns/1ps
`include "spxu_consts.vh"

// four-lane permute of one 64-bit (16-bit lanes) or 128-bit (32-bit lanes) group
module spxu_word_perm #(
  parameter LANE = 16
) (
  input  wire [4*LANE-1:0] srcIn,
  input  wire [7:0]        ctrlByte,
  output wire [4*LANE-1:0] dstOut
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gLane
      wire [1:0] sel;
      assign sel = ctrlByte[2*i+1:2*i];
      assign dstOut[LANE*i +: LANE] = srcIn[LANE*sel +: LANE];
    end
  endgenerate
endmodule // spxu_word_perm

// ### test/spxu_checker_assertions.sv
`timescale 1ns/1ps
`include "spxu_consts.vh"
module spxu_checker (
  input wire         clk,
  input wire         sys_rst,
  input wire         opValid,
  input wire [3:0]   opSel,
  input wire [127:0] srcVec,
  input wire         srcFromMem,
  input wire         resValid,
  input wire [127:0] resVec,
  input wire [31:0]  resInt,
  input wire         resIntWrite,
  input wire         storeValid,
  input wire [1:0]   storeSize
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  function automatic [31:0] mk(input [127:0] s, input n8);
    integer i;
    begin
      mk = 32'h0000_0000;
      for (i = 0; i < 16; i = i + 1) if (!n8 || i < 8) mk[i] = s[8*i+7];
    end
  endfunction
  AST_LAT: assert property (opValid |-> ##2 resValid)
    else $error("result not two cycles after issue");
  AST_NOSPUR: assert property (resValid |-> $past(opValid, 2))
    else $error("result without issue");
  AST_MASKV: assert property (resIntWrite |-> resInt == mk($past(srcVec, 2), $past(srcFromMem, 2)))
    else $error("sign mask value wrong");
  AST_INTW: assert property (opValid && opSel == `SPXU_OP_MASK |-> ##2 resIntWrite)
    else $error("mask write missing");
  AST_STORE: assert property (opValid && opSel >= `SPXU_OP_EXTB |->
    ##2 storeValid && storeSize == $past(opSel[1:0], 2) - 2'h1)
    else $error("store missing or size wrong");
  AST_LOKEEP: assert property (opValid && opSel == `SPXU_OP_LOPERM |->
    ##2 resVec[127:64] == $past(srcVec[127:64], 2))
    else $error("high half not passed");
  AST_HIKEEP: assert property (opValid && opSel == `SPXU_OP_HIPERM |->
    ##2 resVec[63:0] == $past(srcVec[63:0], 2))
    else $error("low half not passed");
  AST_WUP: assert property (opValid && opSel == `SPXU_OP_WPERM64 |->
    ##2 resVec[127:64] == 64'h0000_0000_0000_0000)
    else $error("word permute upper half not zero");
endmodule // spxu_checker
bind spxu_permute_unit spxu_checker u_chk (.clk(clk), .sys_rst(sys_rst), .opValid(opValid),
  .opSel(opSel), .srcVec(srcVec), .srcFromMem(srcFromMem), .resValid(resValid),
  .resVec(resVec), .resInt(resInt), .resIntWrite(resIntWrite), .storeValid(storeValid),
  .storeSize(storeSize));

// ### test/spxu_issue_model.sv
`timescale 1ns/1ps
module spxu_issue_model (
  output reg         opValid,
  output reg [3:0]   opSel,
  output reg [127:0] dstVec,
  output reg [127:0] srcVec,
  output reg [63:0]  memOperand,
  output reg         srcFromMem,
  output reg [127:0] implicitMaskVector,
  output reg [7:0]   shuffleControlByte
);
  // whole op changes at once, so nothing is seen half-updated
  task automatic issue(input v, input [3:0] o, input [127:0] d, s, input [63:0] m,
                       input f, input [127:0] mv, input [7:0] c);
    begin
      {opValid, opSel, dstVec, srcVec, memOperand} = {v, o, d, s, m};
      {srcFromMem, implicitMaskVector, shuffleControlByte} = {f, mv, c};
    end
  endtask
endmodule // spxu_issue_model

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg clk, sys_rst;
  wire opValid, srcFromMem, resValid, resIntWrite, storeValid;
  wire [3:0] opSel;
  wire [127:0] dstVec, srcVec, implicitMaskVector, resVec;
  wire [63:0] memOperand;
  wire [7:0] shuffleControlByte;
  wire [31:0] resInt, storeData;
  wire [1:0] storeSize;
  integer mismatches, compares, cyc, i;
  reg [31:0] seed, r;
  reg [191:0] q[$];
  reg [3:0] oq[$];
  spxu_issue_model issueModel (.opValid(opValid), .opSel(opSel), .dstVec(dstVec),
    .srcVec(srcVec), .memOperand(memOperand), .srcFromMem(srcFromMem),
    .implicitMaskVector(implicitMaskVector), .shuffleControlByte(shuffleControlByte));
  spxu_permute_unit DUT (.clk(clk), .sys_rst(sys_rst), .opValid(opValid), .opSel(opSel),
    .dstVec(dstVec), .srcVec(srcVec), .memOperand(memOperand), .srcFromMem(srcFromMem),
    .implicitMaskVector(implicitMaskVector), .shuffleControlByte(shuffleControlByte),
    .resValid(resValid), .resVec(resVec), .resInt(resInt), .resIntWrite(resIntWrite),
    .storeValid(storeValid), .storeData(storeData), .storeSize(storeSize));
  function automatic [191:0] ex(input [3:0] o, input [127:0] d, s, input [63:0] m,
                                input f, input [127:0] v, input [7:0] c);
    reg [127:0] x;
    reg [31:0] ri, sd;
    reg [63:0] h;
    integer i;
    begin
      x = 128'h0; ri = 32'h0; sd = 32'h0; h = f ? m : s[63:0];
      if (o == 4'h2 || o == 4'h3 || (o >= 4'h9 && o <= 4'hC)) x = (o < 4'h9) ? s : d;
      for (i = 0; i < 16; i = i + 1) case (o)
        4'h0: if (!f || i < 8) ri[i] = s[8*i+7];
        4'h1: if (i < 4) x[16*i+:16] = h[16*c[2*i+:2]+:16];
        4'h2: if (i < 4) x[16*i+:16] = s[16*c[2*i+:2]+:16];
        4'h3: if (i < 4) x[64+16*i+:16] = s[64+16*c[2*i+:2]+:16];
        4'h4: if (i < 4) x[32*i+:32] = s[32*c[2*i+:2]+:32];
        4'h5: x[8*i+:8] = s[8*i+7] ? 8'h00 : d[8*s[8*i+:4]+:8];
        4'h6: x[8*i+:8] = c[i%8] ? s[8*i+:8] : d[8*i+:8];
        4'h7: if (i < 8) x[16*i+:16] = c[i] ? s[16*i+:16] : d[16*i+:16];
        4'h8: x[8*i+:8] = v[8*i+7] ? s[8*i+:8] : d[8*i+:8];
        default: ;
      endcase
      case (o)
        4'h9, 4'hC: x[32*c[1:0]+:32] = m[31:0];
        4'hA: x[8*c[3:0]+:8] = m[7:0];
        4'hB: x[16*c[2:0]+:16] = m[15:0];
        4'hD: sd = {24'h0, s[8*c[3:0]+:8]};
        4'hE: sd = {16'h0, s[16*c[2:0]+:16]};
        4'hF: sd = s[32*c[1:0]+:32];
        default: ;
      endcase
      ex = {sd, ri, x};
    end
  endfunction
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rv(output [127:0] x);
    integer k;
    for (k = 0; k < 4; k = k + 1) begin
      seed = lfsr(seed);
      x[32*k+:32] = seed;
    end
  endtask
  task automatic cmp(input [127:0] got, exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // issue at falling edge after checking what the last rising edge produced
  task automatic step(input v, input [3:0] o, input [7:0] c, input f);
    reg [127:0] d, s, mv;
    reg [191:0] e;
    reg [3:0] p;
    begin
      @(negedge clk);
      if (resValid === 1'b1) begin
        e = q.pop_front();
        p = oq.pop_front();
        if (p == 4'h0) cmp(resInt, e[159:128]);
        else if (p >= 4'hD) cmp(storeData, e[191:160]);
        else cmp(resVec, e[127:0]);
      end
      rv(d); rv(s); rv(mv);
      if (o == 4'h5) s = s & {16{8'h8f}};
      issueModel.issue(v, o, d, s, d[127:64] ^ s[63:0], f, mv, c);
      if (v) begin
        q.push_back(ex(o, d, s, d[127:64] ^ s[63:0], f, mv, c));
        oq.push_back(o);
      end
    end
  endtask
  task summarize;
    begin
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  initial begin
    {mismatches, compares, cyc} = 0;
    seed = 32'h0000_1d62;
    sys_rst = 1'b1;
    issueModel.issue(1'b0, 4'h0, 128'h0, 128'h0, 64'h0, 1'b0, 128'h0, 8'h00);
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    for (i = 0; i < 16; i = i + 1) step(1'b1, i, 8'h1b, i[0]);
    step(1'b1, 4'h6, 8'h00, 1'b0);
    step(1'b1, 4'hA, 8'h0f, 1'b0);
    step(1'b1, 4'hD, 8'h0f, 1'b0);
    step(1'b1, 4'hC, 8'h03, 1'b0);
    step(1'b1, 4'h0, 8'h00, 1'b1);
    $display("corner test done");
    repeat (300) begin
      rv(r);
      step(r[0] | r[1], r[7:4], r[15:8], r[16]);
    end
    repeat (3) step(1'b0, 4'h0, 8'h00, 1'b0);
    cmp(q.size(), 0);
    $display("random test done");
    summarize;
  end
endmodule // tb_top
